// *** stepper_drive_config_fault.v ***
// Four-axis stepper drive configuration and fault supervision
`timescale 1ns/100ps
`include "step_drive_regs.vh"
module stepper_drive_config_fault #(
	parameter NAXIS = 4                              // Axes in the drive
) (
	input  wire                      i_clock,                  // 20 MHz servo clock
	input  wire                      i_rst,                    // Async reset, high
	input  wire                      i_sample,                 // Servo sample enable pulse
	input  wire [NAXIS*32-1:0]       i_reference_position,     // Per-axis reference positions
	input  wire [NAXIS-1:0]          i_cur_wr,                 // Write current select, per axis
	input  wire [`CUR_W-1:0]         i_drive_current_select,   // Current code to write
	input  wire [NAXIS-1:0]          i_hold_wr,                // Write hold setting, per axis
	input  wire [`HOLD_W-1:0]        i_hold_current_mode,      // Hold setting to write
	input  wire [NAXIS-1:0]          i_res_wr,                 // Write resolution, per axis
	input  wire [`RES_W-1:0]         i_step_resolution_select, // Resolution to write
	input  wire [NAXIS-1:0]          i_axis_enable_cmd,        // Enable pulse per axis
	input  wire [NAXIS-1:0]          i_motor_off_cmd,          // Motor-off pulse per axis
	input  wire                      i_emergency_lockout_input,// Lockout pin
	input  wire [NAXIS-1:0]          i_short_detect,           // Short sense pins per axis
	input  wire                      i_drive_power_ok,         // Drive supply good pin
	output reg  [NAXIS-1:0]          o_amp_enable,             // Amplifier enable per axis
	output reg  [NAXIS*`PCT_W-1:0]   o_current_pct,            // Phase current percent
	output reg  [NAXIS*`CUR_W-1:0]   o_drive_current_select,   // Stored current codes
	output reg  [NAXIS*`RES_W-1:0]   o_step_resolution_select, // Stored resolutions
	output reg                       o_fault_report_general,   // Short / power fault
	output reg                       o_fault_report_lockout,   // Lockout status
	output reg                       o_amp_error_handler       // Error handler request pulse
);
	// Two-flop synchronisers for the pins
	reg              elo_s1_r, elo_s2_r;
	reg [NAXIS-1:0]  sh_s1_r, sh_s2_r;
	reg              pwr_s1_r, pwr_s2_r;
	reg              elo_d_r;          // Lockout level one cycle ago
	reg              fault_d_r;        // Drive fault one cycle ago

	// Per-axis stored configuration
	reg [`HOLD_W-1:0] hold_r [0:NAXIS-1];
	reg [NAXIS-1:0]   off_r;           // Axis in motor-off
	reg               latched_r;       // Drive fault held until recovery

	wire [NAXIS-1:0] at_rest;
	wire [NAXIS-1:0] hold_off;
	wire             fault_now = (|sh_s2_r) | ~pwr_s2_r;
	reg              all_hold_zero;
	integer          k;
	integer          j;                // Loop index of the combinational scan

	// Accepted resolution codes only
	function res_ok;
		input [`RES_W-1:0] v;
		begin
			res_ok = (v == `RES_FULL) || (v == `RES_HALF) ||
			         (v == `RES_QUARTER) || (v == `RES_SIXTEENTH); // RQ10
		end
	endfunction

	// Percent current from hold state and resolution
	function [`PCT_W-1:0] pct_of;
		input             rest;
		input [`HOLD_W-1:0] hold;
		input [`RES_W-1:0]  res;
		begin
			if (rest && hold == `HOLD_LOW)
				pct_of = `PCT_LOW;                 // RQ5
			else if (res == `RES_FULL)
				pct_of = `PCT_FULLSTEP;            // RQ11
			else
				pct_of = `PCT_FULL;                // RQ4
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < NAXIS; g = g + 1) begin : ax
			axis_hold u_hold (
				.i_clock     (i_clock),
				.i_rst       (i_rst),
				.i_sample    (i_sample),
				.i_ref_pos   (i_reference_position[g*32 +: 32]),
				.i_hold_mode (hold_r[g]),
				.o_at_rest   (at_rest[g]),
				.o_hold_off  (hold_off[g])
			);
		end
	endgenerate

	// Recovery from a drive fault needs every hold setting back at zero
	always @* begin
		all_hold_zero = 1'b1;
		for (j = 0; j < NAXIS; j = j + 1)
			if (hold_r[j] != `HOLD_FULL)
				all_hold_zero = 1'b0;
	end

	// Pin synchronisers; only the second stage is read by logic
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			elo_s1_r <= 1'b0;
			elo_s2_r <= 1'b0;
			sh_s1_r  <= {NAXIS{1'b0}};
			sh_s2_r  <= {NAXIS{1'b0}};
			pwr_s1_r <= 1'b1;
			pwr_s2_r <= 1'b1;
		end else begin
			elo_s1_r <= i_emergency_lockout_input;
			elo_s2_r <= elo_s1_r;
			sh_s1_r  <= i_short_detect;
			sh_s2_r  <= sh_s1_r;
			pwr_s1_r <= i_drive_power_ok;
			pwr_s2_r <= pwr_s1_r;
		end
	end

	// Configuration storage; each axis only takes its own write strobe
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			for (k = 0; k < NAXIS; k = k + 1) begin
				hold_r[k] <= `HOLD_RESET;
				o_drive_current_select[k*`CUR_W +: `CUR_W]   <= `CUR_RESET; // RQ3
				o_step_resolution_select[k*`RES_W +: `RES_W] <= `RES_RESET;
			end
		end else begin
			for (k = 0; k < NAXIS; k = k + 1) begin
				if (i_cur_wr[k])
					o_drive_current_select[k*`CUR_W +: `CUR_W] <= i_drive_current_select; // RQ2
				if (i_hold_wr[k])
					hold_r[k] <= i_hold_current_mode;               // RQ8
				// Unsupported codes are dropped, keeping the old value
				if (i_res_wr[k] && res_ok(i_step_resolution_select))
					o_step_resolution_select[k*`RES_W +: `RES_W] <= i_step_resolution_select; // RQ19
			end
		end
	end

	// Fault, lockout and enable supervision
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			off_r                  <= {NAXIS{1'b1}};
			latched_r              <= 1'b0;
			elo_d_r                <= 1'b0;
			fault_d_r              <= 1'b0;
			o_fault_report_general <= 1'b0;
			o_fault_report_lockout <= 1'b0;
			o_amp_error_handler    <= 1'b0;
			o_amp_enable           <= {NAXIS{1'b0}};
			o_current_pct          <= {NAXIS*`PCT_W{1'b0}};
		end else begin
			elo_d_r   <= elo_s2_r;
			fault_d_r <= fault_now;
			// Handler request pulses on rising lockout or fault
			o_amp_error_handler <= (elo_s2_r & ~elo_d_r) | (fault_now & ~fault_d_r); // RQ12 RQ17
			o_fault_report_lockout <= elo_s2_r;                                        // RQ12
			// A fault stays latched until the recovery sequence, even if the short goes away
			if (fault_now)
				latched_r <= 1'b1;                                                     // RQ15 RQ16
			else if (latched_r && (&off_r) && all_hold_zero && (|i_axis_enable_cmd))
				latched_r <= 1'b0;                                                     // RQ18
			o_fault_report_general <= fault_now | latched_r;                           // RQ16
			for (k = 0; k < NAXIS; k = k + 1) begin
				// Lockout forces motor-off; enable is refused while lockout or fault stands
				if (elo_s2_r || fault_now || i_motor_off_cmd[k])
					off_r[k] <= 1'b1;                                                  // RQ12
				else if (i_axis_enable_cmd[k] && !latched_r)
					off_r[k] <= 1'b0;                                                  // RQ13
				o_amp_enable[k] <= ~off_r[k] & ~elo_s2_r & ~fault_now & ~latched_r & ~hold_off[k];
				o_current_pct[k*`PCT_W +: `PCT_W] <= off_r[k] ? `PCT_ZERO :
					pct_of(at_rest[k], hold_r[k], o_step_resolution_select[k*`RES_W +: `RES_W]);
			end
		end
	end
endmodule

// *** step_drive_regs.vh ***
// Constants for the four-axis stepper drive configuration and fault block
// Notes on behaviour
// (RQ1) Controller selects active-high step pulses
// (RQ2) Current code 0..3 gives 0.5/0.75/1.0/1.4 A
// (RQ3) Current select resets to code 1
// (RQ4) Hold mode 0 keeps full current
// (RQ5) Hold mode 1 drops to quarter current
// (RQ6) Hold 2..32767 delays enable toggle in samples
// (RQ7) At rest means reference position constant
// (RQ8) Hold setting is stored per axis
// (RQ9) Controller sets stepper type before hold
// (RQ10) Resolution 1,2,4,16 gives full/half/quarter/sixteenth
// (RQ11) Full step limits current to seventy percent
// (RQ12) Lockout disables amplifier, motor off, flags, handler
// (RQ13) Lockout recovery: motor off, wait, enable
// (RQ14) Controller should enable off-on-error with lockout
// (RQ15) Phase, load and ground shorts are faults
// (RQ16) Short fault disables drive, flips general report
// (RQ17) Drive power loss raises amplifier error
// (RQ18) Fault clear: all off, hold 0, enable
// (RQ19) Bad resolution values are rejected
`ifndef STEP_DRIVE_REGS_VH
`define STEP_DRIVE_REGS_VH
`define CUR_RESET      2'h1
`define CUR_W          2
`define HOLD_W         15
`define HOLD_FULL      15'h0000
`define HOLD_LOW       15'h0001
`define HOLD_RESET     15'h0000
`define RES_W          5
`define RES_FULL       5'h01
`define RES_HALF       5'h02
`define RES_QUARTER    5'h04
`define RES_SIXTEENTH  5'h10
`define RES_RESET      5'h10
`define PCT_W          7
`define PCT_FULL       7'h64
`define PCT_LOW        7'h19
`define PCT_FULLSTEP   7'h46
`define PCT_ZERO       7'h00
`endif

// *** axis_hold.v ***
// One axis: rest detection and holding-current / enable delay
`timescale 1ns/100ps
`include "step_drive_regs.vh"
module axis_hold (
	input  wire                  i_clock,      // 20 MHz clock
	input  wire                  i_rst,        // Async reset, high
	input  wire                  i_sample,     // Servo sample enable pulse
	input  wire [31:0]           i_ref_pos,    // Reference position
	input  wire [`HOLD_W-1:0]    i_hold_mode,  // Stored hold setting
	output reg                   o_at_rest,    // Axis at rest
	output reg                   o_hold_off    // Delay expired, drop enable
);
	reg [31:0]         last_pos_r;  // Position at previous sample
	reg [`HOLD_W-1:0]  rest_cnt_r;  // Samples spent at rest

	// Rest is judged once per servo sample, not per clock
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			last_pos_r <= 32'h0000_0000;
			rest_cnt_r <= 15'h0000;
			o_at_rest  <= 1'b1;
			o_hold_off <= 1'b0;
		end else if (i_sample) begin
			last_pos_r <= i_ref_pos;
			o_at_rest  <= (i_ref_pos == last_pos_r); // RQ7
			if (i_ref_pos != last_pos_r) begin
				rest_cnt_r <= 15'h0000;
				o_hold_off <= 1'b0;
			end else if (i_hold_mode > `HOLD_LOW) begin
				// Saturating count so a long rest cannot wrap and re-enable the amplifier;
				// compare the old count against setting minus one to drop on the setting-th rest sample
				if (rest_cnt_r != 15'h7fff)
					rest_cnt_r <= rest_cnt_r + 15'h0001;
				o_hold_off <= (rest_cnt_r >= i_hold_mode - 15'h0001); // RQ6
			end else begin
				o_hold_off <= 1'b0;
			end
		end else if (i_hold_mode <= `HOLD_LOW) begin
			// A hold setting rewritten to 0 or 1 releases the enable at once, not at the next sample
			o_hold_off <= 1'b0;
		end
	end
endmodule

// *** sdc_checker.sv ***
// Port-level assertions for the stepper drive supervisor
`timescale 1ns/100ps
`include "step_drive_regs.vh"
module sdc_checker #(
	parameter NAXIS = 4 // Axes
) (
	input wire                    i_clock, i_rst, i_emergency_lockout_input, i_drive_power_ok, // Clock, reset, pins
	input wire [NAXIS-1:0]        i_cur_wr, i_res_wr, i_short_detect, o_amp_enable, // Strobes, sense, enables
	input wire [`CUR_W-1:0]       i_drive_current_select,  // Code written
	input wire [`RES_W-1:0]       i_step_resolution_select, // Resolution written
	input wire [NAXIS*`CUR_W-1:0] o_drive_current_select,  // Stored codes
	input wire [NAXIS*`RES_W-1:0] o_step_resolution_select, // Stored resolutions
	input wire                    o_fault_report_general, o_fault_report_lockout, o_amp_error_handler // Reports
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// Only the four documented step sizes are legal
	wire res_ok = i_step_resolution_select == `RES_FULL || i_step_resolution_select == `RES_HALF ||
		i_step_resolution_select == `RES_QUARTER || i_step_resolution_select == `RES_SIXTEENTH;
	cur_write_a: assert property (i_cur_wr[0] |=> o_drive_current_select[1:0] == $past(i_drive_current_select))
		else $error("current code not stored");
	res_take_a: assert property (i_res_wr[0] && res_ok |=> o_step_resolution_select[4:0] == $past(i_step_resolution_select))
		else $error("resolution not stored");
	res_keep_a: assert property (i_res_wr[0] && !res_ok |=> $stable(o_step_resolution_select[4:0]))
		else $error("bad resolution accepted");
	lock_flag_a: assert property (i_emergency_lockout_input [*3] |=> o_fault_report_lockout)
		else $error("lockout not reported");
	lock_off_a: assert property (o_fault_report_lockout |-> o_amp_enable == '0)
		else $error("enabled during lockout");
	handler_cause_a: assert property ($rose(o_fault_report_lockout) |-> o_amp_error_handler)
		else $error("handler not raised on lockout");
	handler_one_a: assert property (o_amp_error_handler |=> !o_amp_error_handler)
		else $error("handler pulse too long");
	short_flag_a: assert property (i_short_detect[0] [*3] |=> o_fault_report_general)
		else $error("short not reported");
	fault_off_a: assert property (o_fault_report_general |=> o_amp_enable == '0)
		else $error("enabled during fault");
	power_a: assert property (!i_drive_power_ok [*3] |=> o_fault_report_general)
		else $error("power loss not reported");
	cover property (i_res_wr[0] && !res_ok);
	cover property ($rose(o_fault_report_general));
	cover property ($rose(o_fault_report_lockout));
endmodule
bind stepper_drive_config_fault sdc_checker #(.NAXIS(NAXIS)) i_sdc_checker (.*);

// *** motor_load.sv ***
// Behavioural load of four bipolar stepper motors
`timescale 1ns/100ps
module motor_load (
	input  wire        i_clock,       // Drive clock
	input  wire [3:0]  i_amp_enable,  // Enables per axis
	input  wire [27:0] i_phase_pct,   // Phase current per axis
	input  wire [3:0]  i_short_cmd,   // Bench asks for a shorted winding
	output reg  [3:0]  o_short_detect = 4'h0 // Short sense to the drive
);
	integer k;
	// A short only draws fault current while its phases are driven
	always @(posedge i_clock) begin
		for (k = 0; k < 4; k = k + 1)
			o_short_detect[k] <= i_short_cmd[k] & i_amp_enable[k] & (i_phase_pct[7*k +: 7] != 7'h00);
	end
endmodule

// *** testbench.sv ***
// Self-checking bench for the stepper drive supervisor
`timescale 1ns/100ps
module testbench;
	reg         i_clock = 1'b0, i_rst = 1'b1, i_sample = 1'b0, i_emergency_lockout_input = 1'b0, i_drive_power_ok = 1'b1;
	reg [127:0] i_reference_position = 128'h0;
	reg [3:0]   i_cur_wr = 4'h0, i_hold_wr = 4'h0, i_res_wr = 4'h0, i_axis_enable_cmd = 4'h0, i_motor_off_cmd = 4'h0;
	reg [3:0]   short_cmd = 4'h0;   // Fault injection into the motor model
	reg [1:0]   i_drive_current_select = 2'h0;
	reg [14:0]  i_hold_current_mode = 15'h0;
	reg [4:0]   i_step_resolution_select = 5'h0;
	reg [2:0]   sc = 3'h0;          // Servo sample divider
	wire [3:0]  i_short_detect, o_amp_enable;
	wire [27:0] o_current_pct;
	wire [7:0]  o_drive_current_select;
	wire [19:0] o_step_resolution_select;
	wire        o_fault_report_general, o_fault_report_lockout, o_amp_error_handler;
	integer     miscompares = 0, comparisons = 0, k;
	stepper_drive_config_fault i_stepper_drive_config_fault (.*);
	motor_load i_motor_load (.i_clock(i_clock), .i_amp_enable(o_amp_enable), .i_phase_pct(o_current_pct),
		.i_short_cmd(short_cmd), .o_short_detect(i_short_detect));
	always #25 i_clock = ~i_clock;
	// One sample pulse every eight clocks, so rest spans several samples
	always @(negedge i_clock) begin
		sc <= sc + 3'h1;
		i_sample <= (sc == 3'h3);
	end
	task summarize; begin
		if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	end endtask
	task chk(input [95:0] nm, input [31:0] ex, input [31:0] got); begin
		comparisons = comparisons + 1;
		if (got !== ex) begin
			miscompares = miscompares + 1;
			$display("unexpected %0s: expected %h seen %h", nm, ex, got);
		end
	end endtask
	task tick(input [7:0] n); repeat (n) @(negedge i_clock); endtask
	// One strobe: 0 current, 1 hold, 2 resolution, 3 enable, 4 motor-off
	task put(input [2:0] f, input [3:0] m, input [14:0] v); begin
		i_drive_current_select = v[1:0];
		i_hold_current_mode = v;
		i_step_resolution_select = v[4:0];
		case (f)
			3'h0: i_cur_wr = m;
			3'h1: i_hold_wr = m;
			3'h2: i_res_wr = m;
			3'h3: i_axis_enable_cmd = m;
			default: i_motor_off_cmd = m;
		endcase
		tick(1);
		{i_cur_wr, i_hold_wr, i_res_wr, i_axis_enable_cmd, i_motor_off_cmd} = 20'h0;
		tick(1);
	end endtask
	// Fault clear needs every axis off and every hold at zero first
	task recover; begin
		put(3'h4, 4'hf, 15'h0);
		put(3'h1, 4'hf, 15'h0);
		put(3'h3, 4'hf, 15'h0);
		put(3'h3, 4'hf, 15'h0);
		tick(1);
	end endtask
	initial begin
		#2000000 miscompares = miscompares + 1;
		summarize;
	end
	initial begin
		tick(2); // controller side is taken as stepper with active-high steps
		i_rst = 1'b0;
		tick(1);
		chk("cur reset", 32'h55, o_drive_current_select);
		for (k = 0; k < 4; k = k + 1) begin
			put(3'h0, 4'h1, k[14:0]);
			chk("cur code", 32'h54 + k, o_drive_current_select);
		end
		// Step size 8 lies between legal codes and must be dropped
		for (k = 0; k < 5; k = k + 1) begin
			put(3'h2, 4'h1, 15'h1 << k);
			chk("res sel", 32'h84200 | (k == 3 ? 4 : 1 << k), o_step_resolution_select);
		end
		put(3'h3, 4'h1, 15'h0);
		tick(2);
		chk("pct hold0", 32'h64, o_current_pct[6:0]);
		put(3'h2, 4'h1, 15'h1);
		tick(2);
		chk("pct full", 32'h46, o_current_pct[6:0]);
		put(3'h1, 4'h2, 15'h1); // hold written once the axis is a stepper
		put(3'h3, 4'h2, 15'h0);
		tick(18);
		chk("pct low", 32'h19, o_current_pct[13:7]);
		chk("pct other", 32'h46, o_current_pct[6:0]);
		repeat (20) begin
			i_reference_position[63:32] = i_reference_position[63:32] + 32'h1;
			tick(1);
		end
		chk("pct moving", 32'h64, o_current_pct[13:7]);
		put(3'h1, 4'h4, 15'h3);
		put(3'h3, 4'h4, 15'h0);
		tick(40);
		chk("hold drop", 32'h0, o_amp_enable[2]);
		repeat (20) begin
			i_reference_position[95:64] = i_reference_position[95:64] + 32'h1;
			tick(1);
		end
		chk("hold move", 32'h1, o_amp_enable[2]);
		i_emergency_lockout_input = 1'b1; // off-on-error assumed set on every axis
		tick(4);
		chk("lockout", 32'h1, o_fault_report_lockout);
		put(3'h3, 4'hf, 15'h0);
		tick(1);
		chk("lock en", 32'h0, o_amp_enable);
		i_emergency_lockout_input = 1'b0;
		tick(4);
		put(3'h4, 4'hf, 15'h0);
		tick(2);
		put(3'h3, 4'h1, 15'h0);
		tick(1);
		chk("lock rec", 32'h1, o_amp_enable);
		short_cmd = 4'h1;
		tick(6);
		chk("short", 32'h1, o_fault_report_general);
		short_cmd = 4'h0;
		tick(4);
		put(3'h3, 4'h1, 15'h0);
		tick(1);
		chk("latched", 32'h0, o_amp_enable);
		recover;
		chk("cleared", 32'hf, o_amp_enable);
		i_drive_power_ok = 1'b0;
		tick(4);
		chk("power", 32'h1, o_fault_report_general);
		i_drive_power_ok = 1'b1;
		tick(4);
		recover;
		chk("power rec", 32'hf, o_amp_enable);
		summarize;
	end
endmodule
